// file: src/icm_modulator.sv
/*
 * Infrared carrier modulator with AXI4-Lite register slave and output stage.
 * Assumes one 100 MHz bus clock, a synchronous active-low reset and an AXI4-Lite master
 * that keeps valid and payload steady until the handshake.
 */
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module icm_modulator
	import icm_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output var  logic        infrared_out_pin
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        awrdy;
		logic        wrdy;
		logic        arrdy;
		logic        aw_ok;
		logic [7:0]  aw_addr;
		logic        w_ok;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [5:0]  ctrl;
		logic [1:0]  outctl;
		logic [31:0] carrier;
		logic [15:0] mark;
		logic [15:0] space;
		logic [2:0]  pre;
		logic [7:0]  ccnt;
		logic        chigh;
		logic [15:0] mcnt;
		logic        in_mark;
		logic        mute;
		logic        sec;
		logic        pin;
	} icm_state_t;

	icm_state_t st_r;
	icm_state_t st_nxt;
	logic       src_en;
	logic       unit;
	logic       end_p;
	logic       cdone;
	logic       mod_out;
	logic [7:0] hi_cnt;
	logic [7:0] lo_cnt;

	// ----------------------------------------------------------------
	// source clock divider
	// ----------------------------------------------------------------
	icm_src_div u_div (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (st_r.ctrl[ICM_CTRL_EN]),
		.sel     (st_r.ctrl[ICM_CTRL_DIV_LO +: 2]),
		.en      (src_en)
	);

	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] data,
		input logic [3:0]  strb
	);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = data[8*i +: 8];
			end
		end
		return res;
	endfunction

	always_comb begin
		st_nxt = st_r;
		cdone = 1'b0;
		unit = 1'b0;
		end_p = 1'b0;
		mod_out = 1'b0;
		hi_cnt = st_r.sec ? st_r.carrier[ICM_CAR_SHI +: 8] : st_r.carrier[ICM_CAR_PHI +: 8];
		lo_cnt = st_r.sec ? st_r.carrier[ICM_CAR_SLO +: 8] : st_r.carrier[ICM_CAR_PLO +: 8];

		// ----------------------------------------------------------------
		// write channel: address and data in either order
		// ----------------------------------------------------------------
		if (s_axi_awvalid && st_r.awrdy) begin
			st_nxt.aw_ok = 1'b1;
			st_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_r.wrdy) begin
			st_nxt.w_ok = 1'b1;
			st_nxt.w_data = s_axi_wdata;
			st_nxt.w_strb = s_axi_wstrb;
		end
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (st_nxt.aw_ok && st_nxt.w_ok && !st_nxt.bvalid) begin
			st_nxt.aw_ok = 1'b0;
			st_nxt.w_ok = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = ICM_RESP_OKAY;
			if (st_nxt.aw_addr[7:2] == ICM_OFS_CTRL[7:2]) begin
				// a write of zero must land too, it is how software stops the modulator
				st_nxt.ctrl = 6'(merge(32'(st_r.ctrl), st_nxt.w_data, st_nxt.w_strb));
			end else if (st_nxt.aw_addr[7:2] == ICM_OFS_OUTCTL[7:2]) begin
				st_nxt.outctl = 2'(merge(32'(st_r.outctl), st_nxt.w_data, st_nxt.w_strb));
			end else if (st_nxt.aw_addr[7:2] == ICM_OFS_CARRIER[7:2]) begin
				st_nxt.carrier = merge(st_r.carrier, st_nxt.w_data, st_nxt.w_strb);
			end else if (st_nxt.aw_addr[7:2] == ICM_OFS_MARK[7:2]) begin
				st_nxt.mark = 16'(merge(32'(st_r.mark), st_nxt.w_data, st_nxt.w_strb));
			end else if (st_nxt.aw_addr[7:2] == ICM_OFS_SPACE[7:2]) begin
				st_nxt.space = 16'(merge(32'(st_r.space), st_nxt.w_data, st_nxt.w_strb));
			end else if (st_nxt.aw_addr[7:2] == ICM_OFS_STATUS[7:2]) begin
				st_nxt.bresp = ICM_RESP_OKAY;
			end else begin
				st_nxt.bresp = ICM_RESP_SLVERR;
			end
		end
		st_nxt.awrdy = !st_nxt.aw_ok && !st_nxt.bvalid;
		st_nxt.wrdy = !st_nxt.w_ok && !st_nxt.bvalid;

		// ----------------------------------------------------------------
		// read channel: one-cycle answer
		// ----------------------------------------------------------------
		if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st_r.arrdy) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = ICM_RESP_OKAY;
			st_nxt.rdata = 32'h00000000;
			if (s_axi_araddr[7:2] == ICM_OFS_CTRL[7:2]) begin
				st_nxt.rdata = 32'(st_r.ctrl);
			end else if (s_axi_araddr[7:2] == ICM_OFS_OUTCTL[7:2]) begin
				st_nxt.rdata = 32'(st_r.outctl);
			end else if (s_axi_araddr[7:2] == ICM_OFS_CARRIER[7:2]) begin
				st_nxt.rdata = st_r.carrier;
			end else if (s_axi_araddr[7:2] == ICM_OFS_MARK[7:2]) begin
				st_nxt.rdata = 32'(st_r.mark);
			end else if (s_axi_araddr[7:2] == ICM_OFS_SPACE[7:2]) begin
				st_nxt.rdata = 32'(st_r.space);
			end else if (s_axi_araddr[7:2] == ICM_OFS_STATUS[7:2]) begin
				// carrier set in use is deliberately left out
				st_nxt.rdata = {29'h0, st_r.mute, st_r.in_mark, st_r.pin}; // R8
			end else begin
				st_nxt.rresp = ICM_RESP_SLVERR;
			end
		end
		st_nxt.arrdy = !st_nxt.rvalid;

		// ----------------------------------------------------------------
		// carrier generator and mark/space sequencer
		// ----------------------------------------------------------------
		if (!st_r.ctrl[ICM_CTRL_EN]) begin
			st_nxt.pre = 3'h0;
			st_nxt.ccnt = 8'h00;
			st_nxt.chigh = 1'b1;
			st_nxt.mcnt = 16'h0000;
			st_nxt.in_mark = 1'b1;
			st_nxt.mute = 1'b0;
			st_nxt.sec = 1'b0;
		end else begin
			if (src_en) begin
				st_nxt.pre = st_r.pre + 3'h1;
				// zero counts behave as one, so the carrier never stalls
				if (st_r.chigh && (st_r.ccnt + 8'h01) >= hi_cnt) begin
					st_nxt.chigh = 1'b0;
					st_nxt.ccnt = 8'h00;
				end else if (!st_r.chigh && (st_r.ccnt + 8'h01) >= lo_cnt) begin
					st_nxt.chigh = 1'b1;
					st_nxt.ccnt = 8'h00;
					cdone = 1'b1;
				end else begin
					st_nxt.ccnt = st_r.ccnt + 8'h01;
				end
			end
			if (st_r.ctrl[ICM_CTRL_FSK] && !st_r.ctrl[ICM_CTRL_PLAIN_ENVELOPE_SELECT]) begin
				unit = cdone; // R7
			end else begin
				unit = src_en && st_r.pre == ICM_PRE_LAST; // R2
			end
			if (unit) begin
				if (st_r.in_mark) begin
					if (st_r.mcnt == st_r.mark) begin // R3
						st_nxt.mcnt = 16'h0000;
						if (st_r.space == 16'h0000) begin
							end_p = 1'b1;
						end else begin
							st_nxt.in_mark = 1'b0;
						end
					end else begin
						st_nxt.mcnt = st_r.mcnt + 16'h0001;
					end
				end else if ((st_r.mcnt + 16'h0001) >= st_r.space) begin // R3
					end_p = 1'b1;
				end else begin
					st_nxt.mcnt = st_r.mcnt + 16'h0001;
				end
			end
			if (end_p) begin
				st_nxt.in_mark = 1'b1;
				st_nxt.mcnt = 16'h0000;
				// mute decided per whole period; a clear frees the next mark only
				st_nxt.mute = st_r.ctrl[ICM_CTRL_EXTENDED_SPACE_CTRL]; // R5 R6 R9
				if (st_r.ctrl[ICM_CTRL_FSK] && !st_r.ctrl[ICM_CTRL_PLAIN_ENVELOPE_SELECT]) begin
					st_nxt.sec = !st_r.sec; // R7 R10
				end
			end
		end

		// ----------------------------------------------------------------
		// transmitter stage
		// ----------------------------------------------------------------
		if (st_nxt.ctrl[ICM_CTRL_PLAIN_ENVELOPE_SELECT]) begin
			mod_out = st_nxt.in_mark && !st_nxt.mute; // R14
		end else begin
			mod_out = st_nxt.in_mark && !st_nxt.mute && st_nxt.chigh; // R1
		end
		if (st_nxt.ctrl[ICM_CTRL_EN]) begin
			st_nxt.pin = mod_out ^ st_nxt.outctl[ICM_OUT_POL]; // R11 R13
		end else begin
			st_nxt.pin = st_nxt.outctl[ICM_OUT_LATCH]; // R12
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
			st_r.awrdy <= 1'b1;
			st_r.wrdy <= 1'b1;
			st_r.arrdy <= 1'b1;
			st_r.ctrl <= ICM_RST_CTRL;
			st_r.outctl <= ICM_RST_OUTCTL;
			st_r.carrier <= ICM_RST_CARRIER;
			st_r.mark <= ICM_RST_MARK;
			st_r.space <= ICM_RST_SPACE;
			st_r.chigh <= 1'b1;
			st_r.in_mark <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign s_axi_awready = st_r.awrdy;
	assign s_axi_wready = st_r.wrdy;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_arready = st_r.arrdy;
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;
	assign s_axi_rvalid = st_r.rvalid;
	assign infrared_out_pin = st_r.pin;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_time_carrier: assert property ( // R1
		(st_r.ctrl[ICM_CTRL_EN] && !st_r.ctrl[ICM_CTRL_PLAIN_ENVELOPE_SELECT] && st_r.in_mark && !st_r.mute)
		|-> infrared_out_pin == (st_r.chigh ^ st_r.outctl[ICM_OUT_POL]))
		else $error("time mode mark must carry the carrier");

	chk_unit_rate: assert property ( // R2
		(st_r.ctrl[ICM_CTRL_EN] && $past(st_r.ctrl[ICM_CTRL_EN]) && !st_r.ctrl[ICM_CTRL_FSK]
		&& !$past(st_r.ctrl[ICM_CTRL_FSK])
		&& $changed(st_r.mcnt) && st_r.mcnt != 16'h0000) |-> $past(st_r.pre) == ICM_PRE_LAST)
		else $error("mark/space unit must be eight source clocks");

	chk_fsk_unit: assert property ( // R7
		(st_r.ctrl[ICM_CTRL_EN] && $past(st_r.ctrl[ICM_CTRL_EN]) && st_r.ctrl[ICM_CTRL_FSK]
		&& $past(st_r.ctrl[ICM_CTRL_FSK]) && !$past(st_r.ctrl[ICM_CTRL_PLAIN_ENVELOPE_SELECT])
		&& $changed(st_r.mcnt) && st_r.mcnt != 16'h0000) |-> !$past(st_r.chigh))
		else $error("shift-mode unit must be one carrier period");

	chk_space_idle: assert property ( // R3
		(st_r.ctrl[ICM_CTRL_EN] && !st_r.in_mark)
		|-> infrared_out_pin == st_r.outctl[ICM_OUT_POL])
		else $error("space must be inactive");

	chk_mute_latch: assert property ( // R5
		(st_r.ctrl[ICM_CTRL_EN] && end_p) |=> st_r.mute == $past(st_r.ctrl[ICM_CTRL_EXTENDED_SPACE_CTRL]))
		else $error("extended space not sampled at period end");

	chk_mute_hold: assert property ( // R6
		(st_r.ctrl[ICM_CTRL_EN] && st_r.mute)
		|-> infrared_out_pin == st_r.outctl[ICM_OUT_POL])
		else $error("muted period must stay inactive");

	chk_set_swap: assert property ( // R7
		(st_r.ctrl[ICM_CTRL_EN] && st_r.ctrl[ICM_CTRL_FSK] && !st_r.ctrl[ICM_CTRL_PLAIN_ENVELOPE_SELECT] && end_p)
		|=> st_r.sec != $past(st_r.sec))
		else $error("carrier set must swap each period");

	chk_latch_drive: assert property ( // R12
		$fell(st_r.ctrl[ICM_CTRL_EN]) |-> infrared_out_pin == st_r.outctl[ICM_OUT_LATCH])
		else $error("disabled pin must follow latch");

	chk_plain_envelope_select_level: assert property ( // R14
		(st_r.ctrl[ICM_CTRL_EN] && st_r.ctrl[ICM_CTRL_PLAIN_ENVELOPE_SELECT] && st_r.in_mark && !st_r.mute)
		|-> infrared_out_pin == !st_r.outctl[ICM_OUT_POL])
		else $error("baseband mark must be steady active");

endmodule
`default_nettype wire

// file: src/icm_pkg.sv
/*
 * Shared constants of the infrared carrier modulator: register offsets, field positions,
 * reset values and count limits. Assumes a single 100 MHz bus clock and an AXI4-Lite master.
 */
// What this block does
// [R1] enable, no baseband, no shift selects time mode
// [R2] mark and space in divided-by-eight source units, in carrier periods in shift mode
// [R3] mark lasts count plus one, space count
// [R4] software keeps mark longer than carrier high
// [R5] extended space adds whole mark-space periods
// [R6] extended space can mute a whole mark
// [R7] shift mode swaps carrier sets every period
// [R8] current carrier set is never readable
// [R9] extended space ends after clearing period's space
// [R10] shift-mode extended space alternates both sets
// [R11] enabled modulator drives the infrared pin
// [R12] disabled modulator lets latch drive the pin
// [R13] polarity bit selects active high or low
// [R14] baseband mark is steady active, no carrier
// [R15] divider field divides clock, zero means one
package icm_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ICM_OFS_CTRL    = 8'h00;
	localparam logic [7:0] ICM_OFS_OUTCTL  = 8'h04;
	localparam logic [7:0] ICM_OFS_CARRIER = 8'h08;
	localparam logic [7:0] ICM_OFS_MARK    = 8'h0c;
	localparam logic [7:0] ICM_OFS_SPACE   = 8'h10;
	localparam logic [7:0] ICM_OFS_STATUS  = 8'h14;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int ICM_CTRL_EN     = 0;
	localparam int ICM_CTRL_PLAIN_ENVELOPE_SELECT   = 1;
	localparam int ICM_CTRL_FSK    = 2;
	localparam int ICM_CTRL_EXTENDED_SPACE_CTRL  = 3;
	localparam int ICM_CTRL_DIV_LO = 4;
	localparam int ICM_OUT_LATCH   = 0;
	localparam int ICM_OUT_POL     = 1;
	localparam int ICM_CAR_PHI     = 0;
	localparam int ICM_CAR_PLO     = 8;
	localparam int ICM_CAR_SHI     = 16;
	localparam int ICM_CAR_SLO     = 24;

	// ----------------------------------------------------------------
	// reset values and counts
	// ----------------------------------------------------------------
	localparam logic [5:0]  ICM_RST_CTRL    = 6'h00;
	localparam logic [1:0]  ICM_RST_OUTCTL  = 2'h0;
	localparam logic [31:0] ICM_RST_CARRIER = 32'h01010101;
	localparam logic [15:0] ICM_RST_MARK    = 16'h0000;
	localparam logic [15:0] ICM_RST_SPACE   = 16'h0000;
	localparam logic [2:0]  ICM_PRE_LAST    = 3'h7;
	localparam logic [1:0]  ICM_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  ICM_RESP_SLVERR = 2'h2;

endpackage

// file: src/icm_src_div.sv
/*
 * Source clock divider: turns the bus clock into a one-cycle enable pulse every
 * 2**sel cycles. Assumes sel comes from a register on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module icm_src_div
	import icm_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       run,
	input  wire logic [1:0] sel,
	output var  logic       en
);

	typedef struct packed {
		logic [2:0] cnt;
		logic       en;
	} icm_div_state_t;

	icm_div_state_t st_r;
	icm_div_state_t st_nxt;
	logic [2:0]     last;

	// ----------------------------------------------------------------
	// divide by 1, 2, 4 or 8
	// ----------------------------------------------------------------
	always_comb begin
		last = 3'((4'h1 << sel) - 4'h1);
		st_nxt = st_r;
		st_nxt.en = 1'b0;
		if (!run) begin
			st_nxt.cnt = 3'h0;
		end else if (st_r.cnt >= last) begin
			st_nxt.cnt = 3'h0;
			st_nxt.en = 1'b1; // R15
		end else begin
			st_nxt.cnt = st_r.cnt + 3'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign en = st_r.en;

	chk_div_one: assert property (@(posedge aclk) disable iff (!aresetn) // R15
		(run && $past(run) && sel == 2'h0 && $past(sel) == 2'h0) |-> en)
		else $error("divisor one must enable every cycle");

endmodule
`default_nettype wire

// file: tb/icm_emitter.sv
/*
 * Emitter model at the infrared pin: counts lit cycles and the length of the
 * last finished lit and dark runs. Assumes the pin is a registered level on aclk.
 */
`timescale 1ns/10ps
`default_nettype none
module icm_emitter (
	input  wire logic        aclk,
	input  wire logic        infrared_out_pin,
	input  wire logic        clr,
	output var  logic [15:0] lit_cycles,
	output var  logic [15:0] last_lit,
	output var  logic [15:0] last_dark
);
	logic        prev_r;
	logic [15:0] run_r;

	// ------------------------------------------------------------
	// run tracking
	// ------------------------------------------------------------
	// first run after clr is partial, so callers settle two periods first
	always_ff @(posedge aclk) begin
		prev_r <= infrared_out_pin;
		if (clr) begin
			lit_cycles <= 16'h0000;
			run_r      <= 16'h0000;
		end else begin
			lit_cycles <= lit_cycles + {15'h0000, infrared_out_pin};
			if (infrared_out_pin !== prev_r) begin
				if (prev_r)
					last_lit <= run_r;
				else
					last_dark <= run_r;
				run_r <= 16'h0001;
			end else begin
				run_r <= run_r + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

// file: tb/test_infrared_carrier_modulator.sv
/*
 * Self-checking bench of the modulator: register access over AXI4-Lite and
 * pin timing measured by the emitter model. Assumes the package register map.
 */
`timescale 1ns/10ps
`default_nettype none
module test_infrared_carrier_modulator;
	import icm_pkg::*;

	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] d;
		logic [3:0]  s;
		logic [31:0] q;
		logic [1:0]  r;
	} icm_reg_row_t;
	typedef struct packed {
		logic [5:0]  c;
		logic [1:0]  o;
		logic [31:0] car;
		logic [15:0] m, sp, w, lit, hi, lo;
	} icm_mode_row_t;

	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, pin, clr;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, q;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic [15:0] lit, hi, lo;
	int          failures, checks;

	icm_reg_row_t regs [7] = '{
		'{ICM_OFS_CTRL, 32'hffffffee, 4'hf, 32'h0000002e, ICM_RESP_OKAY},
		'{ICM_OFS_OUTCTL, 32'hffffffff, 4'hf, 32'h00000003, ICM_RESP_OKAY},
		'{ICM_OFS_CARRIER, 32'h12345678, 4'hf, 32'h12345678, ICM_RESP_OKAY},
		'{ICM_OFS_CARRIER, 32'h000000aa, 4'h1, 32'h123456aa, ICM_RESP_OKAY},
		'{ICM_OFS_MARK, 32'hffffabcd, 4'hf, 32'h0000abcd, ICM_RESP_OKAY},
		'{ICM_OFS_SPACE, 32'h00051234, 4'hf, 32'h00001234, ICM_RESP_OKAY},
		'{8'h18, 32'hffffffff, 4'hf, 32'h00000000, ICM_RESP_SLVERR}
	};
	// 16'hffff marks a run length that is not compared
	icm_mode_row_t modes [7] = '{
		'{6'h03, 2'h1, 32'h01010101, 16'h2, 16'h1, 16'd64, 16'd48, 16'd24, 16'd8},
		'{6'h03, 2'h2, 32'h01010101, 16'h2, 16'h1, 16'd64, 16'd16, 16'd8, 16'd24},
		'{6'h13, 2'h0, 32'h01010101, 16'h2, 16'h1, 16'd128, 16'd96, 16'd48, 16'd16},
		// mark of 16 cycles kept above the carrier high time
		'{6'h01, 2'h0, 32'h01010202, 16'h1, 16'h2, 16'd64, 16'd16, 16'd2, 16'd18},
		'{6'h0b, 2'h0, 32'h01010101, 16'h0, 16'h1, 16'd64, 16'd0, 16'hffff, 16'hffff},
		'{6'h05, 2'h0, 32'h02020101, 16'h0, 16'h1, 16'd120, 16'd30, 16'hffff, 16'hffff},
		'{6'h0d, 2'h0, 32'h02020101, 16'h0, 16'h1, 16'd120, 16'd0, 16'hffff, 16'hffff}
	};

	icm_modulator i_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .infrared_out_pin(pin)
	);
	icm_emitter i_emit (
		.aclk(aclk), .infrared_out_pin(pin), .clr(clr),
		.lit_cycles(lit), .last_lit(hi), .last_dark(lo)
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] rsp);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		rsp = bresp;
		bready <= 1'b0;
		if (n == 200) begin
			failures++;
			stop_test();
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rsp);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		rsp = rresp;
		rready <= 1'b0;
		if (n == 200) begin
			failures++;
			stop_test();
		end
	endtask

	task automatic cfg(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] rsp;
		wr(a, d, 4'hf, rsp);
	endtask

	task automatic measure(input logic [15:0] w);
		repeat (w) @(posedge aclk);
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
		repeat (w) @(posedge aclk);
		@(negedge aclk);
	endtask

	task automatic reset_values();
		rd(ICM_OFS_CTRL, q, r);
		check(q, {26'h0, ICM_RST_CTRL});
		rd(ICM_OFS_OUTCTL, q, r);
		check(q, {30'h0, ICM_RST_OUTCTL});
		rd(ICM_OFS_CARRIER, q, r);
		check(q, ICM_RST_CARRIER);
		rd(ICM_OFS_MARK, q, r);
		check(q, {16'h0, ICM_RST_MARK});
		rd(ICM_OFS_SPACE, q, r);
		check(q, {16'h0, ICM_RST_SPACE});
	endtask

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, clr} = 7'h00;
		{awaddr, araddr, wdata, wstrb} = '0;
		failures = 0;
		checks = 0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		check({31'h0, pin}, 32'h0);
		reset_values();
		foreach (regs[i]) begin
			wr(regs[i].a, regs[i].d, regs[i].s, r);
			check({30'h0, r}, {30'h0, regs[i].r});
			rd(regs[i].a, q, r);
			check(q, regs[i].q);
			check({30'h0, r}, {30'h0, regs[i].r});
		end
		wr(ICM_OFS_STATUS, 32'hffffffff, 4'hf, r);
		check({30'h0, r}, {30'h0, ICM_RESP_OKAY});
		foreach (modes[i]) begin
			cfg(ICM_OFS_CTRL, 32'h0);
			cfg(ICM_OFS_CARRIER, modes[i].car);
			cfg(ICM_OFS_MARK, {16'h0, modes[i].m});
			cfg(ICM_OFS_SPACE, {16'h0, modes[i].sp});
			cfg(ICM_OFS_OUTCTL, {30'h0, modes[i].o});
			cfg(ICM_OFS_CTRL, {26'h0, modes[i].c});
			measure(modes[i].w);
			check({16'h0, lit}, {16'h0, modes[i].lit});
			if (modes[i].hi != 16'hffff) begin
				check({16'h0, hi}, {16'h0, modes[i].hi});
				check({16'h0, lo}, {16'h0, modes[i].lo});
			end
			rd(ICM_OFS_STATUS, q, r);
			check({3'h0, q[31:3]}, 32'h0);
		end
		cfg(ICM_OFS_CTRL, 32'h0);
		cfg(ICM_OFS_CARRIER, 32'h01010101);
		cfg(ICM_OFS_CTRL, 32'h0000000b);
		measure(16'd64);
		cfg(ICM_OFS_CTRL, 32'h00000003);
		measure(16'd64);
		check({16'h0, lit}, 32'd32);
		cfg(ICM_OFS_CTRL, 32'h0);
		cfg(ICM_OFS_OUTCTL, 32'h1);
		repeat (3) @(posedge aclk);
		@(negedge aclk);
		check({31'h0, pin}, 32'h1);
		cfg(ICM_OFS_OUTCTL, 32'h3);
		repeat (3) @(posedge aclk);
		@(negedge aclk);
		check({31'h0, pin}, 32'h1);
		cfg(ICM_OFS_CTRL, 32'h00000003);
		repeat (20) @(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		check({31'h0, pin}, 32'h0);
		reset_values();
		stop_test();
	end
endmodule
`default_nettype wire
